/* File: verilog/llc_seq_regs.svh */
`ifndef LLC_SEQ_REGS_SVH
`define LLC_SEQ_REGS_SVH
// Clock period in ns
`define CLK_PERIOD_NS 25
// Gate timing in ns
`define TON_MIN_NS 1000
`define TON_MAX_NS 20000
`define TNO_MIN_NS 100
`define TNO_MAX_NS 1000
// Derived cycle counts: least times round up, longest round down
`define TON_MIN_CYC ((`TON_MIN_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)
`define TON_MAX_CYC (`TON_MAX_NS / `CLK_PERIOD_NS)
`define TNO_MIN_CYC ((`TNO_MIN_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)
`define TNO_MAX_CYC (`TNO_MAX_NS / `CLK_PERIOD_NS)
// Feedback target current in uA, and its code at 1 uA per lsb
`define FB_TARGET_UA 85
// Threshold-difference limits and step sizes (codes)
`define DIFF_MIN 8'h10
`define DIFF_MAX 8'hF0
`define DIFF_LP_STEP 8'h20
// Low-power hold limits (cycles)
`define HOLD_MAX 16'h0400
`endif

/* File: verilog/llc_seq_pkg.sv */
package llc_seq_pkg;
    typedef enum logic [2:0] {
        ST_NOSUP, ST_READOUT, ST_WAITBULK, ST_RUN
    } seq_state_t;
    typedef enum logic [2:0] {
        GS_LOW_ON, GS_LOW_NO, GS_HIGH_ON, GS_HIGH_NO
    } gate_state_t;
    typedef enum logic [1:0] {
        MODE_HP, MODE_LP, MODE_BURST
    } power_mode_t;
endpackage

/* File: verilog/gate_if.sv */
`timescale 1ns/10ps
interface gate_if;
    logic run;
    logic cap_above_high;
    logic cap_below_low;
    logic overcurrent;
    logic near_capacitive;
    logic hb_peak;
    logic current_nonpos;
    logic [15:0] hold_cycles;
    logic low_on;
    logic high_on;
    logic cycle_done;
    modport ctrl (output run, cap_above_high, cap_below_low, overcurrent, near_capacitive, hb_peak,
        current_nonpos, hold_cycles, input low_on, high_on, cycle_done);
    modport drv (input run, cap_above_high, cap_below_low, overcurrent, near_capacitive, hb_peak,
        current_nonpos, hold_cycles, output low_on, high_on, cycle_done);
endinterface

/* File: verilog/gate_driver.sv */
`timescale 1ns/10ps
`include "llc_seq_regs.svh"
module gate_driver
    import llc_seq_pkg::*;
#(
    parameter int TON_MIN = `TON_MIN_CYC,
    parameter int TON_MAX = `TON_MAX_CYC,
    parameter int TNO_MIN = `TNO_MIN_CYC,
    parameter int TNO_MAX = `TNO_MAX_CYC
) (
    input wire logic i_clk,
    input wire logic i_resetn,
    gate_if.drv g
);
    gate_state_t st_reg, st_next;
    logic [15:0] cnt_reg, cnt_next;
    logic low_reg, low_next, high_reg, high_next, done_reg, done_next;

    // ==========================================================
    // Half-bridge state chain
    always_comb begin
        st_next = st_reg;
        cnt_next = cnt_reg + 16'h0001;
        done_next = 1'b0;
        if (!g.run) begin
            st_next = GS_LOW_ON; // Off: low side on charges bootstrap
            cnt_next = 16'h0000;
        end else begin
            unique case (st_reg)
                GS_LOW_ON: begin
                    // Exit only after minimum on-time
                    if (cnt_reg >= 16'(TON_MIN) && (g.cap_below_low || g.overcurrent || g.near_capacitive
                        || cnt_reg >= 16'(TON_MAX))) begin
                        st_next = GS_LOW_NO;
                        cnt_next = 16'h0000;
                    end
                end
                GS_LOW_NO: begin
                    // Wait non-overlap then peak or timeout
                    if (cnt_reg >= 16'(TNO_MIN) && g.current_nonpos && (g.hb_peak || cnt_reg >= 16'(TNO_MAX))) begin
                        st_next = GS_HIGH_ON;
                        cnt_next = 16'h0000;
                    end
                end
                GS_HIGH_ON: begin
                    if (cnt_reg >= 16'(TON_MIN) && (g.cap_above_high || g.overcurrent || g.near_capacitive
                        || cnt_reg >= 16'(TON_MAX))) begin
                        st_next = GS_HIGH_NO;
                        cnt_next = 16'h0000;
                    end
                end
                GS_HIGH_NO: begin
                    // Hold period in low power stretches the dead time
                    if (cnt_reg >= 16'(TNO_MIN) + g.hold_cycles && (g.hb_peak || cnt_reg >= 16'(TNO_MAX)
                        + g.hold_cycles)) begin
                        st_next = GS_LOW_ON;
                        cnt_next = 16'h0000;
                        done_next = 1'b1;
                    end
                end
            endcase
        end
        // Next outputs decoded from next state: never both on
        low_next = (st_next == GS_LOW_ON);
        high_next = (st_next == GS_HIGH_ON) && g.run;
    end

    always_ff @(posedge i_clk or negedge i_resetn) begin
        if (!i_resetn) begin
            st_reg <= GS_LOW_ON;
            cnt_reg <= 16'h0000;
            low_reg <= 1'b0;
            high_reg <= 1'b0;
            done_reg <= 1'b0;
        end else begin
            st_reg <= st_next;
            cnt_reg <= cnt_next;
            low_reg <= low_next;
            high_reg <= high_next;
            done_reg <= done_next;
        end
    end

    assign g.low_on = low_reg;
    assign g.high_on = high_reg;
    assign g.cycle_done = done_reg;

    // ==========================================================
    // Checks
    a_gate_no_overlap: assert property (@(posedge i_clk) disable iff (!i_resetn)
        !(low_reg && high_reg)) else $error("Both gates on");
    a_low_min_on: assert property (@(posedge i_clk) disable iff (!i_resetn)
        (st_reg == GS_LOW_ON && st_next == GS_LOW_NO) |-> cnt_reg >= 16'(TON_MIN))
        else $error("Low side left before min on-time");
    a_dead_before_high: assert property (@(posedge i_clk) disable iff (!i_resetn)
        $rose(high_reg) |-> $past(st_reg) == GS_LOW_NO) else $error("High on without dead time");
    a_off_low_on: assert property (@(posedge i_clk) disable iff (!i_resetn)
        !g.run |=> low_reg && !high_reg) else $error("Off state gates wrong");
    c_full_cycle: cover property (@(posedge i_clk) disable iff (!i_resetn) done_reg);
    c_ocp_exit: cover property (@(posedge i_clk) disable iff (!i_resetn)
        st_reg == GS_LOW_ON && st_next == GS_LOW_NO && g.overcurrent);
endmodule

/* File: verilog/llc_sequencer.sv */
`timescale 1ns/10ps
`include "llc_seq_regs.svh"
// Functional notes
// - Supply below stop: no-supply, stop switching
// - No-supply: charge both rails from HV
// - Both started: read settings resistances
// - Bulk sense pulled low before settings done
// - Settings done: release and monitor bulk
// - Switch only after bulk start level
// - Low feedback current: stop HV charging
// - Cap above high: high gate off
// - Dead time before low gate on
// - Cap below low: low gate off
// - Dead time before high gate on
// - Less feedback current widens thresholds
// - Regulate feedback current toward 85 uA
// - Ramp threshold difference slowly at start
// - Start difference from low-gate resistance
// - High power: difference only, no hold
// - Low demand: enter low-power mode
// - Low-power entry steps difference up
// - Low power: difference, then duty, then burst
// - Off: low gate on, high off
// - Low gate keeps minimum on-time
// - Leave low conduction on exit condition
// - Overcurrent, capacitive, max on-time also exit
// - Non-overlap min, then peak or max
module llc_sequencer
    import llc_seq_pkg::*;
#(
    parameter int DW = 8,
    parameter int RAMP_DIV = 64
) (
    input wire logic I_CLK,
    input wire logic I_RESETN,
    input wire logic i_main_supply_ok,
    input wire logic i_main_supply_started,
    input wire logic i_regulated_supply_ok,
    input wire logic i_regulated_supply_started,
    input wire logic i_settings_valid,
    input wire logic [DW-1:0] i_low_gate_setting,
    input wire logic [DW-1:0] i_lowpower_entry_level,
    input wire logic i_bulk_start_reached,
    input wire logic [DW-1:0] i_feedback_current_pin,
    input wire logic [DW-1:0] i_resonant_cap_sense,
    input wire logic i_overcurrent_guard,
    input wire logic i_near_capacitive,
    input wire logic i_hb_peak,
    input wire logic i_current_nonpos,
    output logic O_HV_CHARGE_MAIN,
    output logic O_HV_CHARGE_REG,
    output logic O_SETTINGS_READ,
    output logic O_BULK_PULL_LOW,
    output logic O_LOW_GATE_OUT,
    output logic O_HIGH_GATE_OUT,
    output logic [DW-1:0] O_CAP_UPPER_THRESHOLD,
    output logic [DW-1:0] O_CAP_LOWER_THRESHOLD,
    output logic [1:0] O_MODE
);
    localparam logic [DW-1:0] MID = DW'(1 << (DW - 1));
    localparam logic [DW-1:0] FB_TARGET = DW'(`FB_TARGET_UA);

    gate_if g();

    seq_state_t seq_reg, seq_next;
    power_mode_t mode_reg, mode_next;
    logic [DW-1:0] diff_reg, diff_next, target_reg, target_next, offset_reg, offset_next;
    logic [DW-1:0] start_diff_reg, start_diff_next;
    logic [15:0] hold_reg, hold_next, ramp_reg, ramp_next;
    logic ramping_reg, ramping_next, hvm_reg, hvm_next;
    logic [DW-1:0] up_reg, lo_reg;

    function automatic logic [DW-1:0] sat_add(input logic [DW-1:0] a, input logic [DW-1:0] b);
        logic [DW:0] s;
        s = {1'b0, a} + {1'b0, b};
        sat_add = s[DW] ? '1 : s[DW-1:0];
    endfunction

    function automatic logic [DW-1:0] sat_sub(input logic [DW-1:0] a, input logic [DW-1:0] b);
        sat_sub = (a > b) ? a - b : '0;
    endfunction

    // ==========================================================
    // Start-up state chain
    always_comb begin
        seq_next = seq_reg;
        start_diff_next = start_diff_reg;
        unique case (seq_reg)
            ST_NOSUP: if (i_main_supply_started && i_regulated_supply_started) begin
                seq_next = ST_READOUT;
            end
            ST_READOUT: if (i_settings_valid) begin
                seq_next = ST_WAITBULK;
                start_diff_next = i_low_gate_setting;
            end
            ST_WAITBULK: if (i_bulk_start_reached) begin
                seq_next = ST_RUN;
            end
            ST_RUN: ;
        endcase
        // Supply loss overrides everything
        if (!i_main_supply_ok || !i_regulated_supply_ok) begin
            seq_next = ST_NOSUP;
        end
    end

    // ==========================================================
    // Power demand, optobias offset and mode selection
    always_comb begin
        offset_next = offset_reg;
        ramp_next = ramp_reg + 16'h0001;
        // Slow offset loop pulls feedback toward target
        if (ramp_reg == 16'(RAMP_DIV - 1)) begin
            ramp_next = 16'h0000;
            if (i_feedback_current_pin < FB_TARGET) begin
                offset_next = sat_add(offset_reg, DW'(1));
            end else if (i_feedback_current_pin > FB_TARGET) begin
                offset_next = sat_sub(offset_reg, DW'(1));
            end
        end
        // Lower feedback current means more demand
        target_next = sat_add(~i_feedback_current_pin, offset_reg);
        mode_next = mode_reg;
        diff_next = diff_reg;
        hold_next = hold_reg;
        ramping_next = ramping_reg;
        if (seq_reg != ST_RUN) begin
            mode_next = MODE_HP;
            diff_next = start_diff_reg;
            hold_next = 16'h0000;
            ramping_next = 1'b1;
        end else if (ramping_reg) begin
            // Soft start: step once per cycle toward target
            if (g.cycle_done) begin
                if (diff_reg >= target_reg) begin
                    ramping_next = 1'b0;
                end else begin
                    diff_next = diff_reg + DW'(1);
                end
            end
        end else begin
            unique case (mode_reg)
                MODE_HP: begin
                    diff_next = target_reg;
                    hold_next = 16'h0000;
                    if (target_reg < i_lowpower_entry_level) begin
                        mode_next = MODE_LP;
                        diff_next = sat_add(target_reg, `DIFF_LP_STEP);
                    end
                end
                MODE_LP, MODE_BURST: begin
                    // Difference first, then hold, then burst
                    // Compared one bit wider so a high entry level cannot wrap the exit level
                    if ({1'b0, target_reg} >= {1'b0, i_lowpower_entry_level} + (DW + 1)'(`DIFF_LP_STEP)) begin
                        mode_next = MODE_HP;
                    end else if (g.cycle_done) begin
                        if (diff_reg > `DIFF_MIN && hold_reg == 16'h0000) begin
                            diff_next = diff_reg - DW'(1);
                        end else if (target_reg < diff_reg) begin
                            if (hold_reg < `HOLD_MAX) begin
                                hold_next = hold_reg + 16'h0001;
                            end else begin
                                mode_next = MODE_BURST;
                            end
                        end else if (hold_reg != 16'h0000) begin
                            hold_next = hold_reg - 16'h0001;
                            mode_next = MODE_LP;
                        end
                    end
                end
            endcase
        end
        // HV charge of main supply: off once feedback low while running
        hvm_next = (seq_reg != ST_RUN) || (i_feedback_current_pin >= FB_TARGET && hvm_reg);
    end

    // Thresholds placed symmetrically around mid-scale
    always_ff @(posedge I_CLK or negedge I_RESETN) begin
        if (!I_RESETN) begin
            seq_reg <= ST_NOSUP;
            mode_reg <= MODE_HP;
            diff_reg <= `DIFF_MIN;
            target_reg <= '0;
            offset_reg <= '0;
            start_diff_reg <= `DIFF_MIN;
            hold_reg <= 16'h0000;
            ramp_reg <= 16'h0000;
            ramping_reg <= 1'b1;
            hvm_reg <= 1'b1;
            up_reg <= MID;
            lo_reg <= MID;
        end else begin
            seq_reg <= seq_next;
            mode_reg <= mode_next;
            diff_reg <= diff_next;
            target_reg <= target_next;
            offset_reg <= offset_next;
            start_diff_reg <= start_diff_next;
            hold_reg <= hold_next;
            ramp_reg <= ramp_next;
            ramping_reg <= ramping_next;
            hvm_reg <= hvm_next;
            up_reg <= sat_add(MID, {1'b0, diff_next[DW-1:1]});
            lo_reg <= sat_sub(MID, {1'b0, diff_next[DW-1:1]});
        end
    end

    // ==========================================================
    // Gate driver hookup; cap comparison done here against live thresholds
    assign g.run = (seq_reg == ST_RUN) && (seq_next == ST_RUN);
    assign g.cap_above_high = i_resonant_cap_sense > up_reg;
    assign g.cap_below_low = i_resonant_cap_sense < lo_reg;
    assign g.overcurrent = i_overcurrent_guard;
    assign g.near_capacitive = i_near_capacitive;
    assign g.hb_peak = i_hb_peak;
    assign g.current_nonpos = i_current_nonpos;
    assign g.hold_cycles = hold_reg;

    gate_driver u_gate (
        .i_clk(I_CLK),
        .i_resetn(I_RESETN),
        .g(g)
    );

    // ==========================================================
    // Registered outputs
    always_ff @(posedge I_CLK or negedge I_RESETN) begin
        if (!I_RESETN) begin
            O_HV_CHARGE_MAIN <= 1'b0;
            O_HV_CHARGE_REG <= 1'b0;
            O_SETTINGS_READ <= 1'b0;
            O_BULK_PULL_LOW <= 1'b1;
            O_LOW_GATE_OUT <= 1'b0;
            O_HIGH_GATE_OUT <= 1'b0;
            O_CAP_UPPER_THRESHOLD <= MID;
            O_CAP_LOWER_THRESHOLD <= MID;
            O_MODE <= 2'h0;
        end else begin
            O_HV_CHARGE_MAIN <= (seq_reg == ST_NOSUP) || hvm_reg;
            O_HV_CHARGE_REG <= (seq_reg == ST_NOSUP);
            O_SETTINGS_READ <= (seq_reg == ST_READOUT);
            O_BULK_PULL_LOW <= (seq_reg == ST_NOSUP) || (seq_reg == ST_READOUT);
            O_LOW_GATE_OUT <= g.low_on && !g.high_on;
            O_HIGH_GATE_OUT <= g.high_on && !g.low_on;
            O_CAP_UPPER_THRESHOLD <= up_reg;
            O_CAP_LOWER_THRESHOLD <= lo_reg;
            O_MODE <= mode_reg;
        end
    end

    // ==========================================================
    // Checks
    a_supply_loss_stop: assert property (@(posedge I_CLK) disable iff (!I_RESETN)
        !i_main_supply_ok |=> seq_reg == ST_NOSUP ##2 !O_HIGH_GATE_OUT) else $error("No stop on supply loss");
    a_bulk_pull_hold: assert property (@(posedge I_CLK) disable iff (!I_RESETN)
        seq_reg == ST_READOUT |=> O_BULK_PULL_LOW) else $error("Bulk sense released early");
    a_run_needs_bulk: assert property (@(posedge I_CLK) disable iff (!I_RESETN)
        $rose(seq_reg == ST_RUN) |-> $past(i_bulk_start_reached)) else $error("Ran before bulk level");
    a_start_diff_load: assert property (@(posedge I_CLK) disable iff (!I_RESETN)
        (seq_reg == ST_READOUT && i_settings_valid && i_main_supply_ok && i_regulated_supply_ok)
        |=> start_diff_reg == $past(i_low_gate_setting)) else $error("Start difference not taken");
    a_lp_entry_step: assert property (@(posedge I_CLK) disable iff (!I_RESETN)
        (mode_reg == MODE_HP && mode_next == MODE_LP && seq_next == ST_RUN)
        |=> diff_reg == sat_add($past(target_reg), `DIFF_LP_STEP)) else $error("No step on LP entry");
    a_hp_no_hold: assert property (@(posedge I_CLK) disable iff (!I_RESETN)
        (mode_reg == MODE_HP && !ramping_reg && seq_reg == ST_RUN && seq_next == ST_RUN) |=> hold_reg == 16'h0000)
        else $error("Hold in high power");
    a_out_no_overlap: assert property (@(posedge I_CLK) disable iff (!I_RESETN)
        !(O_LOW_GATE_OUT && O_HIGH_GATE_OUT)) else $error("Gate outputs overlap");
    a_thresh_order: assert property (@(posedge I_CLK) disable iff (!I_RESETN)
        O_CAP_UPPER_THRESHOLD >= O_CAP_LOWER_THRESHOLD) else $error("Thresholds inverted");
    c_reach_run: cover property (@(posedge I_CLK) disable iff (!I_RESETN) $rose(seq_reg == ST_RUN));
    c_enter_lp: cover property (@(posedge I_CLK) disable iff (!I_RESETN) $rose(mode_reg == MODE_LP));
    c_enter_burst: cover property (@(posedge I_CLK) disable iff (!I_RESETN) $rose(mode_reg == MODE_BURST));
endmodule

/* File: bench/llc_stage_model.sv */
`timescale 1ns/10ps
// ========================================
// Half-bridge stage and comparator model
module llc_stage_model #(
    parameter int PEAK_DLY = 6
) (
    input wire logic i_clk,
    input wire logic i_low_on,
    input wire logic i_high_on,
    input wire logic i_stall,
    output logic [7:0] o_cap,
    output logic o_peak,
    output logic o_nonpos
);
    logic [7:0] dead_cnt;
    initial begin
        o_cap = 8'h80;
        dead_cnt = 8'h00;
    end
    // Cap swings with the conducting gate; stall freezes it to force timeouts
    always @(posedge i_clk) begin
        if (!i_stall && i_high_on && o_cap < 8'hFE) begin
            o_cap <= o_cap + 8'h02;
        end else if (!i_stall && i_low_on && o_cap > 8'h01) begin
            o_cap <= o_cap - 8'h02;
        end
        dead_cnt <= (i_low_on || i_high_on) ? 8'h00 : dead_cnt + 8'h01;
    end
    // Slow stage never shows a peak, so only the max dead time can end it
    assign o_peak = !i_stall && (dead_cnt == PEAK_DLY);
    // Current reverses a little after both switches open
    assign o_nonpos = (dead_cnt >= 8'h02);
endmodule

/* File: bench/tb_llc_sequencer.sv */
`timescale 1ns/10ps
// ========================================
// Sequencer bench
module tb_llc_sequencer;
    import llc_seq_pkg::*;
    logic clk = 1'b0;
    logic rstn = 1'b0;
    logic m_ok, m_st, r_ok, r_st, set_ok, bulk, oc, ncap, stall, peak, nonpos;
    logic [7:0] lg_set, lp_lvl, fb, cap, up, dn, u0;
    logic chg_m, chg_r, set_rd, pull, lo, hi;
    logic [1:0] mode;
    int err_count = 0;
    int total_checks = 0;
    int cyc = 0;
    int n;

    // 40 MHz clock
    always #12.5 clk = ~clk;

    llc_sequencer #(.DW(8), .RAMP_DIV(64)) DUT (.I_CLK(clk), .I_RESETN(rstn),
        .i_main_supply_ok(m_ok), .i_main_supply_started(m_st), .i_regulated_supply_ok(r_ok),
        .i_regulated_supply_started(r_st), .i_settings_valid(set_ok), .i_low_gate_setting(lg_set),
        .i_lowpower_entry_level(lp_lvl), .i_bulk_start_reached(bulk), .i_feedback_current_pin(fb),
        .i_resonant_cap_sense(cap), .i_overcurrent_guard(oc), .i_near_capacitive(ncap),
        .i_hb_peak(peak), .i_current_nonpos(nonpos), .O_HV_CHARGE_MAIN(chg_m), .O_HV_CHARGE_REG(chg_r),
        .O_SETTINGS_READ(set_rd), .O_BULK_PULL_LOW(pull), .O_LOW_GATE_OUT(lo), .O_HIGH_GATE_OUT(hi),
        .O_CAP_UPPER_THRESHOLD(up), .O_CAP_LOWER_THRESHOLD(dn), .O_MODE(mode));

    llc_stage_model #(.PEAK_DLY(6)) stage (.i_clk(clk), .i_low_on(lo), .i_high_on(hi),
        .i_stall(stall), .o_cap(cap), .o_peak(peak), .o_nonpos(nonpos));

    // ========================================
    // Shared helpers
    task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
        total_checks++;
        if (seen !== exp) begin
            err_count++;
            $display("[ERR] %0t seen %h expected %h", $time, seen, exp);
        end
    endtask

    // Inputs move 2 ns after the edge so the design samples settled values
    task automatic step(input int k);
        repeat (k) @(posedge clk);
        #2;
    endtask

    // Cycles until a gate reaches a level, capped so a stuck gate cannot hang
    task automatic wait_g(input bit h, input logic v, output int t);
        t = 0;
        while ((h ? hi : lo) !== v && t < 1000) begin
            step(1);
            t++;
        end
    endtask

    task automatic report_and_stop;
        if (err_count == 0 && total_checks > 0) begin
            $display("NO MISMATCHES");
        end else begin
            $display("MISMATCHES SEEN");
        end
        $finish;
    endtask

    // Hang guard, well above the roughly 4k cycles the run needs
    always @(posedge clk) begin
        cyc <= cyc + 1;
        if (cyc == 30000) begin
            err_count++;
            report_and_stop();
        end
    end

    // Shoot-through watch over the whole run
    always @(negedge clk) begin
        if (lo === 1'b1 && hi === 1'b1) begin
            chk({lo, hi}, 2'b00);
        end
    end

    // ========================================
    // Scenarios
    task automatic t_startup;
        chk(set_rd, 1'b0);
        m_st = 1'b1;
        step(3);
        chk(set_rd, 1'b0);
        r_st = 1'b1;
        step(3);
        chk(set_rd, 1'b1);
        chk(pull, 1'b1);
        set_ok = 1'b1;
        step(3);
        chk({set_rd, pull}, 2'b00);
        step(20);
        chk({lo, hi}, 2'b10);
        bulk = 1'b1;
        wait_g(0, 1'b1, n);
        chk(n <= 6, 1'b1);
        chk(hi, 1'b0);
        chk(chg_m, 1'b1);
    endtask

    // Normal cycles: on-time floor, dead times, threshold crossings
    task automatic t_switch;
        for (int i = 0; i < 2; i++) begin
            wait_g(0, 1'b0, n);
            chk(n >= 39 && n <= 800, 1'b1);
            chk(cap <= dn, 1'b1);
            wait_g(1, 1'b1, n);
            chk(n >= 4 && n <= 44, 1'b1);
            wait_g(1, 1'b0, n);
            chk(cap >= up, 1'b1);
            wait_g(0, 1'b1, n);
            chk(n >= 4 && n <= 44, 1'b1);
            chk(mode, 2'd0);
        end
    endtask

    // Frozen cap: max on-time, no peak, then commanded faults
    task automatic t_faults;
        wait_g(1, 1'b1, n);
        wait_g(1, 1'b0, n);
        stall = 1'b1;
        wait_g(0, 1'b1, n);
        wait_g(0, 1'b0, n);
        chk(n >= 795 && n <= 806, 1'b1);
        wait_g(1, 1'b1, n);
        chk(n >= 38 && n <= 46, 1'b1);
        for (int k = 0; k < 2; k++) begin
            wait_g(0, 1'b1, n);
            step(60);
            oc = (k == 0);
            ncap = (k == 1);
            wait_g(0, 1'b0, n);
            chk(n <= 5, 1'b1);
            oc = 1'b0;
            ncap = 1'b0;
        end
        stall = 1'b0;
    endtask

    // Falling feedback stops HV charging and widens thresholds evenly
    task automatic t_widen;
        u0 = up;
        fb = 8'h00;
        step(3);
        chk(chg_m, 1'b0);
        step(2500);
        chk(up > u0, 1'b1);
        chk(up - 8'h80, 8'h80 - dn);
    endtask

    task automatic t_lowpower;
        lp_lvl = 8'hFF;
        fb = 8'hFF;
        n = 0;
        while (mode === 2'd0 && n < 4000) begin
            step(1);
            n++;
        end
        chk(mode === 2'd1 || mode === 2'd2, 1'b1);
    endtask

    // Each supply monitor in turn stops switching and restarts the chain
    task automatic t_loss;
        for (int k = 0; k < 2; k++) begin
            m_ok = (k != 0);
            r_ok = (k != 1);
            step(4);
            chk({lo, hi, pull, chg_r}, 4'b1011);
            step(30);
            chk({lo, hi}, 2'b10);
            m_ok = 1'b1;
            r_ok = 1'b1;
            wait_g(1, 1'b1, n);
            chk(n <= 120, 1'b1);
        end
    endtask

    // ========================================
    // Main sequence
    initial begin
        {m_st, r_st, set_ok, bulk, oc, ncap, stall} = '0;
        {m_ok, r_ok} = 2'b11;
        lg_set = 8'h40;
        lp_lvl = 8'h00;
        fb = 8'hC8;
        step(5);
        chk({lo, hi, chg_m, chg_r, mode}, 6'h00);
        chk(pull, 1'b1);
        chk({up, dn}, 16'h8080);
        step(1);
        rstn = 1'b1;
        step(2);
        chk({chg_m, chg_r, pull}, 3'b111);
        t_startup();
        t_switch();
        t_faults();
        t_widen();
        t_lowpower();
        t_loss();
        report_and_stop();
    end
endmodule
